// file: design/epb_bus_ctl.sv
// Emulator pod bus control: strobes, mapper, decode, tracking, PV latches
`timescale 1ns/100ps
`default_nettype none
`include "epb_defs.svh"
module epb_bus_ctl (
  input wire logic clk, // Processor clock, 50 MHz
  input wire logic resetn, // Async reset, active low
  input wire logic out_of_circuit, // Pod not in target
  input wire logic pod_int_disable, // Control bit: disable user irqs
  input wire logic emu_break_irq_n, // Break request, low true
  input wire logic [2:0] target_irq_n, // Target priority levels
  input wire logic addr_strobe_n, // Processor address strobe
  input wire logic upper_data_n, // Processor upper data strobe
  input wire logic lower_data_n, // Processor lower data strobe
  input wire logic read_write, // High for read
  input wire logic test_mode, // Break strobe feedback loop
  input wire logic defibrillate_n, // Defibrillate, low true
  input wire logic dma_tag_enable, // DMA tagging enable
  input wire logic alt_data_strobe_n, // Alternate data strobe
  input wire logic alt_strobe_n, // Tagging hold-off, low true
  input wire logic [23:1] cpu_addr, // Processor address
  input wire logic [2:0] fc, // Function codes
  input wire logic dma_direction, // DMA direction
  input wire logic fc_map_select_n, // Mapper mode select
  input wire logic map_write, // Control board mapper write
  input wire logic [23:1] emu_addr_lines, // Mapper load address
  input wire logic map_data, // Mapper data bit zero
  input wire logic internal_clock_sel, // Clock source select
  input wire logic program_fetch, // Program cycle strobe
  input wire logic [23:0] next_addr, // Next processor address
  input wire logic verify_select_1_n, // First PV select
  input wire logic user_mem_flag_n, // User memory flag
  output logic [2:0] cpu_priority_irq_n, // To processor
  output logic emu_write_ind_n, // Latched write
  output logic byte_ind_n, // Latched lower strobe
  output logic upper_byte_ind_n, // Latched upper strobe
  output logic emu_addr_bit0, // Copy of upper-byte
  output logic addr_status_latch_n, // Address/status latch
  output logic analysis_strobe_n, // Analysis strobe
  output logic valid_memory_strobe, // Valid memory
  output logic write_valid_n, // Write data valid
  output logic fc_holdoff_n, // Held high
  output logic user_memory_hit_n, // Mapper result
  output logic clock_from_internal, // Clock source routing
  output logic prefetch_match_buf, // Address equal flag
  output logic addr_level7_n, // Address level 7
  output logic priority_level7_n, // IPL level 7
  output logic irq_ack_decode_n, // Raw ack decode (registered)
  output epb_pkg::epb_status_t status, // Analysis status
  output logic [15:0] buffered_data, // PV readback data
  output logic buffered_data_oe_n // Readback drive enable, low
);
  // ==========================================================
  // Interrupt gating
  logic user_int_gate_n;
  assign user_int_gate_n = !(out_of_circuit || pod_int_disable);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cpu_priority_irq_n <= 3'h7;
    end else if (!emu_break_irq_n) begin
      cpu_priority_irq_n <= 3'h0;
    end else if (!user_int_gate_n) begin
      cpu_priority_irq_n <= 3'h7;
    end else begin
      cpu_priority_irq_n <= target_irq_n;
    end
  end

  // ==========================================================
  // Strobe latching
  // Delayed address strobe stands in for the 30 ns delay line
  logic [`EPB_AS_DELAY_CYC:0] as_dly;
  epb_pkg::epb_strobes_t lat;
  logic strobe_clear, sync_fall, sync_rise, stage2, rd_dly;
  logic combined_strobe_n;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      as_dly <= '1;
    end else begin
      as_dly <= {as_dly[`EPB_AS_DELAY_CYC-1:0], addr_strobe_n};
    end
  end
  // Address strobe with no data strobe (address error) also clears
  assign strobe_clear = !defibrillate_n || dma_tag_enable ||
    (!as_dly[`EPB_AS_DELAY_CYC] && lat.upper_n && lat.lower_n &&
     upper_data_n && lower_data_n) ||
    (stage2 && !test_mode);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lat <= '{upper_n: 1'b1, lower_n: 1'b1, read: 1'b1};
    end else if (strobe_clear) begin
      lat <= '{upper_n: 1'b1, lower_n: 1'b1, read: 1'b1};
    end else if (!addr_strobe_n && !as_dly[`EPB_AS_DELAY_CYC]) begin
      lat.upper_n <= lat.upper_n && upper_data_n;
      lat.lower_n <= lat.lower_n && lower_data_n;
      lat.read <= read_write;
    end
  end
  assign combined_strobe_n = lat.upper_n && lat.lower_n;

  // ==========================================================
  // Synchronisers and latch pulse
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync_fall <= 1'b0;
      rd_dly <= 1'b0;
      sync_rise <= 1'b0;
      stage2 <= 1'b0;
    end else if (strobe_clear) begin
      sync_fall <= 1'b0;
      rd_dly <= 1'b0;
      sync_rise <= 1'b0;
      stage2 <= 1'b0;
    end else begin
      sync_fall <= !combined_strobe_n;
      rd_dly <= sync_fall && lat.read;
      // Rising edge seen once the processor releases both data strobes
      sync_rise <= sync_fall && upper_data_n && lower_data_n;
      stage2 <= sync_rise;
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      addr_status_latch_n <= 1'b1;
    end else if (lat.read) begin
      addr_status_latch_n <= !(rd_dly && !sync_rise);
    end else begin
      addr_status_latch_n <= !(sync_fall && !sync_rise);
    end
  end

  // ==========================================================
  // Indicators and memory strobes
  logic vma_raw;
  logic [`EPB_WDV_LEN:0] wdv_line;
  assign vma_raw = sync_rise && !combined_strobe_n && !status.irq_ack &&
    alt_strobe_n && fc_holdoff_n;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      emu_write_ind_n <= 1'b1;
      byte_ind_n <= 1'b1;
      upper_byte_ind_n <= 1'b1;
      emu_addr_bit0 <= 1'b1;
      analysis_strobe_n <= 1'b1;
      valid_memory_strobe <= 1'b0;
      fc_holdoff_n <= 1'b1;
    end else begin
      emu_write_ind_n <= lat.read;
      byte_ind_n <= lat.lower_n;
      upper_byte_ind_n <= lat.upper_n;
      emu_addr_bit0 <= lat.upper_n;
      analysis_strobe_n <= !(sync_rise ||
        (dma_tag_enable && !alt_data_strobe_n));
      valid_memory_strobe <= vma_raw;
      fc_holdoff_n <= 1'b1;
    end
  end
  // Tapped delay line, qualified by write and valid memory
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wdv_line <= '0;
      write_valid_n <= 1'b1;
    end else begin
      wdv_line <= {wdv_line[`EPB_WDV_LEN-1:0], vma_raw && !lat.read};
      write_valid_n <= !wdv_line[`EPB_WDV_LEN];
    end
  end

  // ==========================================================
  // User memory mapper
  logic map_mem [0:`EPB_MAP_DEPTH-1];
  logic [14:0] map_rd_addr, map_wr_addr;
  assign map_rd_addr = fc_map_select_n ?
    {cpu_addr[23:12], cpu_addr[11:9]} :
    {cpu_addr[23:12], status.fc_n};
  assign map_wr_addr = {emu_addr_lines[23:12], emu_addr_lines[11:9]};
  always_ff @(posedge clk) begin
    if (map_write) begin
      map_mem[map_wr_addr] <= map_data;
    end
  end
  // Stored high marks target memory, so a hit drives low
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      user_memory_hit_n <= 1'b1;
    end else begin
      user_memory_hit_n <= !map_mem[map_rd_addr];
    end
  end

  // ==========================================================
  // Clock source
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      clock_from_internal <= 1'b1;
    end else begin
      clock_from_internal <= internal_clock_sel;
    end
  end

  // ==========================================================
  // Prefetch tracking counters
  logic [`EPB_TRK_COUNT:0] carry;
  logic [`EPB_TRK_COUNT-1:0] nib_eq;
  logic [23:0] track_word;
  logic [23:0] fetch_word;
  logic [23:0] next_word;
  logic mismatch;
  // Counters hold word addresses: count bit 0 is address bit 1
  assign fetch_word = {1'b0, cpu_addr};
  assign next_word = {1'b0, next_addr[23:1]};
  assign carry[0] = program_fetch;
  // Compare against the fetch address to decide reload
  assign mismatch = program_fetch && (track_word != fetch_word);
  genvar gi;
  generate
    for (gi = 0; gi < `EPB_TRK_COUNT; gi = gi + 1) begin : g_trk
      epb_track_nibble u_nib (
        .clk(clk),
        .resetn(resetn),
        .load(mismatch),
        .load_val(fetch_word[gi*4 +: 4]),
        .cin(carry[gi]),
        .cmp_val(next_word[gi*4 +: 4]),
        .count(track_word[gi*4 +: 4]),
        .cout(carry[gi+1]),
        .eq(nib_eq[gi])
      );
    end
  endgenerate
  // Per-nibble equalities are ANDed, then latched for the board
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prefetch_match_buf <= 1'b0;
    end else begin
      prefetch_match_buf <= &nib_eq;
    end
  end

  // ==========================================================
  // Decodes and analysis status
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      addr_level7_n <= 1'b1;
      priority_level7_n <= 1'b1;
      irq_ack_decode_n <= 1'b1;
      status <= '{irq_ack: 1'b0, fc_n: 3'h7, dma_n: 1'b1};
    end else begin
      addr_level7_n <= !(cpu_addr[3:1] == `EPB_LEVEL7);
      priority_level7_n <= !(cpu_priority_irq_n == 3'h0);
      irq_ack_decode_n <= !((cpu_addr[23:4] == `EPB_HI_ADDR_ONES) &&
        (&fc));
      status.irq_ack <= (cpu_addr[23:4] == `EPB_HI_ADDR_ONES) &&
        (&fc);
      status.fc_n <= ~fc;
      status.dma_n <= !dma_direction;
    end
  end

  // ==========================================================
  // Performance verification latches
  logic [23:1] pv_addr;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pv_addr <= '0;
    end else if (!addr_strobe_n && !read_write && !upper_data_n) begin
      pv_addr <= cpu_addr;
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      buffered_data <= 16'h0000;
      buffered_data_oe_n <= 1'b1;
    end else begin
      buffered_data <= pv_addr[23:8];
      buffered_data_oe_n <= !(!verify_select_1_n && read_write &&
        !addr_strobe_n && !cpu_addr[1]);
    end
  end
  logic unused_ok;
  assign unused_ok = user_mem_flag_n;
endmodule // epb_bus_ctl
`default_nettype wire

// file: design/epb_defs.svh
// Constants for the emulator pod bus control block
`ifndef EPB_DEFS_SVH
`define EPB_DEFS_SVH
// ==========================================================
// Timing
`define EPB_CLK_NS 20
`define EPB_AS_DELAY_NS 30
`define EPB_AS_DELAY_CYC ((`EPB_AS_DELAY_NS + `EPB_CLK_NS - 1) / `EPB_CLK_NS)
`define EPB_WDV_TAP_NS 50
`define EPB_WDV_TAPS 3
`define EPB_WDV_TAP_CYC (`EPB_WDV_TAP_NS / `EPB_CLK_NS)
`define EPB_WDV_LEN (`EPB_WDV_TAPS * `EPB_WDV_TAP_CYC)
// Decode constants
`define EPB_LEVEL7 3'h7
`define EPB_TRK_WIDTH 4
`define EPB_TRK_COUNT 6
`define EPB_MAP_DEPTH 32768
`define EPB_HI_ADDR_ONES 20'hfffff
`endif

// file: design/epb_pkg.sv
// Types for the emulator pod bus control block
package epb_pkg;
  typedef struct packed {
    logic upper_n;
    logic lower_n;
    logic read;
  } epb_strobes_t;
  typedef struct packed {
    logic irq_ack;
    logic [2:0] fc_n;
    logic dma_n;
  } epb_status_t;
  typedef enum logic [1:0] {
    EPB_IDLE = 2'b00,
    EPB_ACTIVE = 2'b01,
    EPB_CLOSE = 2'b10
  } epb_cyc_t;
endpackage

// file: design/epb_track_nibble.sv
// One 4-bit prefetch tracking counter stage with carry chain
`timescale 1ns/100ps
`default_nettype none
`include "epb_defs.svh"
module epb_track_nibble (
  input wire logic clk, // Clock
  input wire logic resetn, // Async reset, active low
  input wire logic load, // Load new address
  input wire logic [`EPB_TRK_WIDTH-1:0] load_val, // Value to load
  input wire logic cin, // Carry in (advance)
  input wire logic [`EPB_TRK_WIDTH-1:0] cmp_val, // Next address nibble
  output logic [`EPB_TRK_WIDTH-1:0] count, // Current count
  output logic cout, // Carry out
  output logic eq // Count equals compare
);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count <= '0;
    end else if (load) begin
      // Load then still advance one word
      count <= load_val + {{(`EPB_TRK_WIDTH-1){1'b0}}, cin};
    end else if (cin) begin
      count <= count + 4'h1;
    end
  end
  // Carry must follow the value being loaded, not the stale count
  assign cout = cin && ((load ? load_val : count) == 4'hf);
  assign eq = (count == cmp_val);
endmodule // epb_track_nibble
`default_nettype wire

// file: test/emulator_pod_bus_control_tb_top.sv
// Self-checking testbench for the pod bus control block
`timescale 1ns/100ps
`default_nettype none
module emulator_pod_bus_control_tb_top;
  logic clk, resetn, out_of_circuit, pod_int_disable, emu_break_irq_n;
  logic addr_strobe_n, upper_data_n, lower_data_n, read_write, test_mode;
  logic defibrillate_n, dma_tag_enable, alt_data_strobe_n, alt_strobe_n;
  logic dma_direction, fc_map_select_n, internal_clock_sel, program_fetch;
  logic verify_select_1_n, user_mem_flag_n, map_write, map_data;
  logic [23:1] cpu_addr, emu_addr_lines;
  logic [2:0] fc, target_irq_n, cpu_priority_irq_n, ind;
  logic [23:0] next_addr;
  logic emu_write_ind_n, byte_ind_n, upper_byte_ind_n, emu_addr_bit0;
  logic addr_status_latch_n, analysis_strobe_n, valid_memory_strobe;
  logic write_valid_n, fc_holdoff_n, user_memory_hit_n, clock_from_internal;
  logic prefetch_match_buf, addr_level7_n, priority_level7_n;
  logic irq_ack_decode_n, buffered_data_oe_n, vma, wdv, an, oe;
  logic [15:0] buffered_data, pv;
  epb_pkg::epb_status_t status;
  int fail_count, n_checks, lat, lat_wr;
  epb_bus_ctl dut (.*);
  epb_board_model board (.*);
  always #10 clk = ~clk;
  // ==========================================================
  // Shared tasks
  task chk(input logic [15:0] g, input logic [15:0] e, input string m);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // One processor cycle; strobes held six clocks, then released
  task bus(input logic rd, un, ln, input logic [23:1] a);
    @(posedge clk);
    cpu_addr <= a;
    read_write <= rd;
    {addr_strobe_n, upper_data_n, lower_data_n} <= {1'h0, un, ln};
    {lat, vma, wdv, an} = {32'hffffffff, 3'h0};
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      if (i == 5) {addr_strobe_n, upper_data_n, lower_data_n} <= 3'h7;
      #1;
      if (!addr_status_latch_n && lat < 0) lat = i;
      vma |= valid_memory_strobe;
      wdv |= !write_valid_n;
      an |= !analysis_strobe_n;
      if (i == 5) ind = {emu_write_ind_n, byte_ind_n, upper_byte_ind_n};
      if (i == 3) pv = buffered_data;
      if (i == 3) oe = buffered_data_oe_n;
    end
  endtask
  task irq_case(input logic oc, pd, bk, input logic [2:0] e);
    @(posedge clk);
    {out_of_circuit, pod_int_disable, emu_break_irq_n} <= {oc, pd, bk};
    tick(2);
    chk(cpu_priority_irq_n, e, "priority irq lines");
    chk(priority_level7_n, e != 3'h0, "priority level 7");
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    {clk, resetn, out_of_circuit, pod_int_disable, read_write} = 5'h0;
    {test_mode, dma_tag_enable, dma_direction, program_fetch} = 4'h0;
    {internal_clock_sel, fc, cpu_addr, next_addr} = 0;
    {emu_break_irq_n, addr_strobe_n, upper_data_n, lower_data_n} = 4'hf;
    {defibrillate_n, alt_data_strobe_n, alt_strobe_n} = 3'h7;
    {fc_map_select_n, verify_select_1_n, user_mem_flag_n} = 3'h7;
    repeat (20) @(posedge clk);
    resetn <= 1'h1;
    board.set_irq(3'h5);
    irq_case(0, 0, 1, 3'h5);
    irq_case(1, 0, 1, 3'h7);
    irq_case(0, 1, 1, 3'h7);
    irq_case(0, 0, 0, 3'h0);
    irq_case(0, 0, 1, 3'h5);
    chk(clock_from_internal, 0, "target clock routing");
    bus(0, 0, 0, 23'h12345);
    lat_wr = lat;
    chk(vma, 1, "write vma");
    chk(wdv, 1, "write valid");
    chk(an, 1, "analysis strobe");
    chk(ind, 3'h0, "write indicators");
    verify_select_1_n <= 1'h0;
    bus(1, 1, 0, 23'h00c44);
    chk(lat - lat_wr, 1, "read latch delay");
    chk(wdv, 0, "write valid on read");
    chk(ind, 3'h5, "read indicators");
    chk(pv, 16'h0246, "pv readback");
    chk(oe, 0, "pv readback drive");
    verify_select_1_n <= 1'h1;
    alt_strobe_n <= 1'h0;
    bus(0, 0, 0, 23'h00100);
    chk(vma, 0, "vma during tagging");
    alt_strobe_n <= 1'h1;
    defibrillate_n <= 1'h0;
    bus(0, 0, 0, 23'h00100);
    chk(vma, 0, "vma under defibrillate");
    defibrillate_n <= 1'h1;
    test_mode <= 1'h1;
    bus(0, 0, 0, 23'h00100);
    chk(emu_write_ind_n, 0, "test mode keeps latch");
    {test_mode, defibrillate_n} <= 2'h0;
    tick(2);
    defibrillate_n <= 1'h1;
    fc <= 3'h7;
    bus(1, 0, 0, 23'h7fffff);
    chk(vma, 0, "vma in ack cycle");
    chk(irq_ack_decode_n, 0, "ack decode");
    chk(addr_level7_n, 0, "level 7 decode");
    fc <= 3'h0;
    dma_direction <= 1'h1;
    tick(2);
    chk({status.fc_n, status.dma_n}, 4'he, "status");
    dma_tag_enable <= 1'h1;
    alt_data_strobe_n <= 1'h0;
    tick(2);
    chk(analysis_strobe_n, 0, "tagging analysis");
    {dma_tag_enable, alt_data_strobe_n} <= 2'h1;
    board.load({15'h1238, 8'h00}, 1'h1);
    board.load({15'h1239, 8'h00}, 1'h0);
    cpu_addr <= {15'h1238, 8'h00};
    tick(3);
    chk(user_memory_hit_n, 0, "map hit");
    cpu_addr <= {15'h1239, 8'h00};
    tick(3);
    chk(user_memory_hit_n, 1, "map miss");
    fc_map_select_n <= 1'h0;
    fc <= 3'h6;
    tick(3);
    chk(user_memory_hit_n, 1, "fc map miss");
    fc <= 3'h7;
    tick(3);
    chk(user_memory_hit_n, 0, "fc map hit");
    next_addr <= 24'h000100;
    cpu_addr <= 23'h000080;
    program_fetch <= 1'h1;
    tick(1);
    program_fetch <= 1'h0;
    next_addr <= 24'h000102;
    tick(3);
    chk(prefetch_match_buf, 1, "prefetch match");
    next_addr <= 24'h000104;
    tick(3);
    chk(prefetch_match_buf, 0, "prefetch mismatch");
    internal_clock_sel <= 1'h1;
    tick(2);
    chk(clock_from_internal, 1, "clock routing");
    complete_run();
  end
endmodule // emulator_pod_bus_control_tb_top
bind epb_bus_ctl epb_checker u_chk (.*);
`default_nettype wire

// file: test/epb_board_model.sv
// Control board and target model: mapper loads, target interrupts
`timescale 1ns/100ps
`default_nettype none
module epb_board_model (
  input wire logic clk, // Clock
  output logic map_write, // Mapper write strobe
  output logic [23:1] emu_addr_lines, // Mapper load address
  output logic map_data, // Mapper data bit
  output logic [2:0] target_irq_n // Target levels
);
  initial begin
    map_write = 1'h0;
    emu_addr_lines = 23'h0;
    map_data = 1'h0;
    target_irq_n = 3'h7;
  end
  task load(input logic [23:1] a, input logic d);
    @(posedge clk);
    map_write <= 1'h1;
    emu_addr_lines <= a;
    map_data <= d;
    @(posedge clk);
    map_write <= 1'h0;
    // Released lines must not keep showing the last value
    emu_addr_lines <= ~a;
    map_data <= ~d;
  endtask
  task set_irq(input logic [2:0] l);
    @(posedge clk);
    target_irq_n <= l;
  endtask
endmodule // epb_board_model
`default_nettype wire

// file: test/epb_checker.sv
// Assertion checker for the pod bus control block
`timescale 1ns/100ps
`default_nettype none
module epb_checker (
  input wire logic clk, // Clock
  input wire logic resetn, // Reset, low
  input wire logic out_of_circuit, // Pod out
  input wire logic pod_int_disable, // Irq disable
  input wire logic emu_break_irq_n, // Break
  input wire logic [2:0] target_irq_n, // Target levels
  input wire logic [23:1] cpu_addr, // Address
  input wire logic [2:0] fc, // Function codes
  input wire logic dma_direction, // DMA direction
  input wire logic internal_clock_sel, // Clock select
  input wire logic [2:0] cpu_priority_irq_n, // To processor
  input wire logic emu_addr_bit0, // Address bit 0
  input wire logic upper_byte_ind_n, // Upper byte
  input wire logic valid_memory_strobe, // Valid memory
  input wire logic write_valid_n, // Write valid
  input wire logic fc_holdoff_n, // Hold-off
  input wire logic clock_from_internal, // Clock routing
  input wire logic addr_level7_n, // Address level 7
  input wire logic irq_ack_decode_n, // Ack decode
  input wire epb_pkg::epb_status_t status // Status
);
  wire logic gate_c = out_of_circuit | pod_int_disable;
  wire logic ack_c = (&cpu_addr[23:4]) & (&fc);
  wire logic lv7_c = &cpu_addr[3:1];
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // ==========================================================
  // Interrupt routing
  property p_gate;
    gate_c && emu_break_irq_n |=> cpu_priority_irq_n == 3'h7;
  endproperty
  a_gate: assert property (p_gate)
    else $error("gated irq lines not high");
  property p_brk;
    !gate_c && !emu_break_irq_n |=> cpu_priority_irq_n == 3'h0;
  endproperty
  a_brk: assert property (p_brk)
    else $error("break did not present level 7");
  property p_pass;
    !gate_c && emu_break_irq_n |=> cpu_priority_irq_n == $past(target_irq_n);
  endproperty
  a_pass: assert property (p_pass)
    else $error("target levels not passed");
  // ==========================================================
  // Strobes and indicators
  property p_bit0;
    emu_addr_bit0 == upper_byte_ind_n;
  endproperty
  a_bit0: assert property (p_bit0)
    else $error("address bit 0 differs from upper byte");
  property p_hold;
    fc_holdoff_n == 1'h1;
  endproperty
  a_hold: assert property (p_hold)
    else $error("hold-off went low");
  property p_wdv;
    $fell(write_valid_n) |-> $past(valid_memory_strobe, 7);
  endproperty
  a_wdv: assert property (p_wdv)
    else $error("write valid without valid memory");
  // ==========================================================
  // Decodes, clock and status
  property p_clk;
    $past(resetn) |-> clock_from_internal == $past(internal_clock_sel);
  endproperty
  a_clk: assert property (p_clk)
    else $error("clock routing wrong");
  property p_lev7;
    $past(resetn) |-> addr_level7_n == !$past(lv7_c);
  endproperty
  a_lev7: assert property (p_lev7)
    else $error("address level 7 decode wrong");
  property p_ack;
    $past(resetn) |-> irq_ack_decode_n == !$past(ack_c);
  endproperty
  a_ack: assert property (p_ack)
    else $error("ack decode wrong");
  property p_stat;
    $past(resetn) |-> status.fc_n == ~$past(fc)
      && status.dma_n == !$past(dma_direction);
  endproperty
  a_stat: assert property (p_stat)
    else $error("status latch wrong");
endmodule // epb_checker
`default_nettype wire
